// >>> hw/prw_watchdog.sv
// What this block does
// R1: after reset the counter runs down from all ones, once per instruction clock
// R2: an underflow sets the first underflow flag
// R3: underflow with first flag set sets second flag and raises watchdog reset
// R4: watchdog reset turns on the reset pin transistor, driving it low
// R5: software restarts the watchdog within 65534 machine cycles
// R6: watchdog reset acts only while the guard enable flag is one
// R7: disable then restart clears the guard enable flag
// R8: disable alone leaves the watchdog running and enabled
// R9: enable flag forced to one at system reset and RAM back-up entry
// R10: restart with first flag set clears it and skips the next instruction
// R11: restart with first flag clear does not skip
// R12: restart test-and-skip works while the watchdog reset is disabled
// R13: power-down entry reloads the counter and clears the first flag
// R14: software clears the first flag with restart just before power-down
// R15: watchdog is active again after each return from power-down
// R16: the disable-restart pair counts only in consecutive instruction cycles
// R17: watchdog-caused reset clears both flags and reloads the counter
`timescale 1ns/100ps
`default_nettype none
`include "prw_consts.svh"

module prw_watchdog
#(
    parameter int CNT_W = `PRW_CNT_W,
    parameter int HOLD_CYC = `PRW_RST_HOLD_CYC
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // cpu side
    input wire prw_pkg::prw_cmd_t cmd,
    output prw_pkg::prw_status_t status,
    output logic [CNT_W-1:0] runaway_down_counter,
    // open-drain reset pin
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n
);
    import prw_pkg::*;

    localparam logic [`PRW_HOLD_W-1:0] HOLD_LAST = `PRW_HOLD_W'(HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(`PRW_CNT_ZERO);

    prw_main_t s_r;
    prw_main_t s_nxt;

    logic restart_exec;
    logic disable_exec;
    logic underflow;
    logic pair;
    logic ext_reset;
    logic reinit;
    logic cnt_load;
    logic cnt_dec;
    logic [CNT_W-1:0] count;

    assign restart_exec = cmd.retire && (cmd.op == PRW_OP_GUARD_RESTART);
    assign disable_exec = cmd.retire && (cmd.op == PRW_OP_GUARD_DISABLE);

    // pin pulled low by someone else while we are not driving it
    assign ext_reset = !reset_pin_in && s_r.pin_oe_n;

    // underflow is the count pulse arriving while the counter already reads zero
    assign underflow = (s_r.st == PRW_ST_RUN) && cmd.instr_tick && (count == CNT_ZERO); // R2

    prw_pair_detect u_pair
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .clear(reinit || (s_r.st != PRW_ST_RUN)),
        .retire(cmd.retire),
        .is_disable(cmd.op == PRW_OP_GUARD_DISABLE),
        .is_restart(cmd.op == PRW_OP_GUARD_RESTART),
        .pair(pair)
    );

    // the end of the reset pulse, or a foreign reset, acts as a system reset
    assign reinit = ext_reset
        || ((s_r.st == PRW_ST_RESET) && (s_r.hold_cnt == HOLD_LAST)); // R17

    // counting stops while the reset pin is held, then restarts from all ones
    assign cnt_load = reinit || cmd.power_down_entry; // R13 R17
    assign cnt_dec = cmd.instr_tick && (s_r.st == PRW_ST_RUN); // R1

    prw_down_counter #(
        .WIDTH(CNT_W),
        .INIT(CNT_W'(`PRW_CNT_INIT))
    ) u_cnt
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(cnt_load),
        .dec(cnt_dec),
        .count(count)
    );

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.skip_next = 1'b0;
        s_nxt.pin_out = 1'b0;
        case (s_r.st)
            PRW_ST_RUN:
            begin
                if (ext_reset)
                begin
                    s_nxt.guard_enable_flag = 1'b1; // R9
                    s_nxt.first_underflow_flag = 1'b0;
                    s_nxt.second_underflow_flag = 1'b0;
                end
                else
                begin
                    // test-and-skip ignores the enable flag
                    if (restart_exec && s_r.first_underflow_flag)
                    begin
                        s_nxt.first_underflow_flag = 1'b0; // R10 R12
                        s_nxt.skip_next = 1'b1; // R10
                    end
                    // no skip when the flag was clear: skip_next stays low (R11)
                    if (pair)
                    begin
                        s_nxt.guard_enable_flag = 1'b0; // R7
                    end
                    // a lone disable only arms the pair detector (R8)
                    if (underflow)
                    begin
                        if (s_r.first_underflow_flag && s_r.guard_enable_flag) // R3 R6
                        begin
                            s_nxt.second_underflow_flag = 1'b1; // R3
                            s_nxt.watchdog_reset = 1'b1; // R3
                            s_nxt.pin_oe_n = 1'b0; // R4
                            s_nxt.hold_cnt = '0;
                            s_nxt.st = PRW_ST_RESET;
                        end
                        else
                        begin
                            // set wins over a restart in the same cycle
                            s_nxt.first_underflow_flag = 1'b1; // R2
                        end
                    end
                    if (cmd.power_down_entry)
                    begin
                        s_nxt.first_underflow_flag = 1'b0; // R13
                        s_nxt.guard_enable_flag = 1'b1; // R9
                    end
                    if (cmd.power_down_return)
                    begin
                        s_nxt.guard_enable_flag = 1'b1; // R15
                    end
                end
            end
            PRW_ST_RESET:
            begin
                s_nxt.hold_cnt = s_r.hold_cnt + `PRW_HOLD_W'(1);
                if (reinit)
                begin
                    s_nxt.st = PRW_ST_RUN;
                    s_nxt.guard_enable_flag = 1'b1; // R9
                    s_nxt.first_underflow_flag = 1'b0; // R17
                    s_nxt.second_underflow_flag = 1'b0; // R17
                    s_nxt.watchdog_reset = 1'b0;
                    s_nxt.pin_oe_n = 1'b1;
                    s_nxt.hold_cnt = '0;
                end
            end
            default:
            begin
                s_nxt.st = PRW_ST_RUN;
                s_nxt.pin_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s_r.st <= PRW_ST_RUN;
            s_r.guard_enable_flag <= 1'b1; // R9
            s_r.first_underflow_flag <= 1'b0;
            s_r.second_underflow_flag <= 1'b0;
            s_r.watchdog_reset <= 1'b0;
            s_r.skip_next <= 1'b0;
            s_r.pin_out <= 1'b0;
            s_r.pin_oe_n <= 1'b1;
            s_r.hold_cnt <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign status.guard_enable_flag = s_r.guard_enable_flag;
    assign status.first_underflow_flag = s_r.first_underflow_flag;
    assign status.second_underflow_flag = s_r.second_underflow_flag;
    assign status.watchdog_reset = s_r.watchdog_reset;
    assign status.skip_next = s_r.skip_next;
    assign runaway_down_counter = count;
    assign reset_pin_out = s_r.pin_out;
    assign reset_pin_oe_n = s_r.pin_oe_n;

endmodule
`default_nettype wire

// >>> hw/prw_consts.svh
`ifndef PRW_CONSTS_SVH
`define PRW_CONSTS_SVH

// down-counter geometry and reload value
`define PRW_CNT_W 16
`define PRW_CNT_INIT 16'hffff
`define PRW_CNT_ZERO 16'h0000

// reference clock and watchdog reset pulse on the pin
`define PRW_CLK_MHZ 50
`define PRW_RST_HOLD_NS 2000
`define PRW_RST_HOLD_CYC ((`PRW_RST_HOLD_NS * `PRW_CLK_MHZ + 999) / 1000)
`define PRW_HOLD_W 8

`endif

// >>> hw/prw_pkg.sv
`include "prw_consts.svh"

package prw_pkg;

    // instruction retired by the cpu in the current cycle
    typedef enum logic [2:0] {
        PRW_OP_OTHER = 3'h0,
        PRW_OP_GUARD_RESTART = 3'h1,
        PRW_OP_GUARD_DISABLE = 3'h2,
        PRW_OP_POWER_OFF_ARM = 3'h3,
        PRW_OP_POWER_OFF = 3'h4
    } prw_op_t;

    typedef struct packed {
        logic instr_tick;
        logic retire;
        prw_op_t op;
        logic power_down_entry;
        logic power_down_return;
    } prw_cmd_t;

    typedef struct packed {
        logic guard_enable_flag;
        logic first_underflow_flag;
        logic second_underflow_flag;
        logic watchdog_reset;
        logic skip_next;
    } prw_status_t;

    typedef enum logic [0:0] {
        PRW_ST_RUN = 1'b0,
        PRW_ST_RESET = 1'b1
    } prw_state_t;

    typedef struct packed {
        prw_state_t st;
        logic guard_enable_flag;
        logic first_underflow_flag;
        logic second_underflow_flag;
        logic watchdog_reset;
        logic skip_next;
        logic pin_out;
        logic pin_oe_n;
        logic [`PRW_HOLD_W-1:0] hold_cnt;
    } prw_main_t;

    typedef struct packed {
        logic [`PRW_CNT_W-1:0] count;
    } prw_cnt_state_t;

    typedef struct packed {
        logic armed;
    } prw_pair_state_t;

endpackage

// >>> hw/prw_down_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "prw_consts.svh"

module prw_down_counter
#(
    parameter int WIDTH = `PRW_CNT_W,
    parameter logic [WIDTH-1:0] INIT = `PRW_CNT_INIT
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // control
    input wire logic load,
    input wire logic dec,
    // state
    output logic [WIDTH-1:0] count
);
    import prw_pkg::*;

    logic [WIDTH-1:0] s_r;
    logic [WIDTH-1:0] s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (load)
        begin
            s_nxt = INIT;
        end
        else if (dec)
        begin
            // wraps from zero to all ones, as a binary counter does
            s_nxt = s_r - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s_r <= INIT;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign count = s_r;

endmodule
`default_nettype wire

// >>> hw/prw_pair_detect.sv
`timescale 1ns/100ps
`default_nettype none

module prw_pair_detect
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // retired instruction
    input wire logic clear,
    input wire logic retire,
    input wire logic is_disable,
    input wire logic is_restart,
    // result
    output logic pair
);
    import prw_pkg::*;

    prw_pair_state_t s_r;
    prw_pair_state_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (clear)
        begin
            s_nxt.armed = 1'b0;
        end
        else if (retire)
        begin
            // any other instruction in between drops the arming
            s_nxt.armed = is_disable; // R16
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign pair = retire && is_restart && s_r.armed && !clear; // R16

endmodule
`default_nettype wire

// >>> dv/prw_watchdog_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module prw_watchdog_mon
#(
    parameter int CNT_W = 16,
    parameter int HOLD_CYC = 100
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // cpu side
    input wire prw_pkg::prw_cmd_t cmd,
    input wire prw_pkg::prw_status_t status,
    input wire logic [CNT_W-1:0] runaway_down_counter,
    // reset pin
    input wire logic reset_pin_in,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n
);
    import prw_pkg::*;
    int lo_cnt;
    logic run;
    logic uf;
    // requests are refused during the pin pulse and a foreign reset
    assign run = !status.watchdog_reset && reset_pin_in && !cmd.power_down_entry;
    assign uf = run && cmd.instr_tick && runaway_down_counter == '0;
    always_ff @(posedge ref_clk)
        lo_cnt <= (srst || reset_pin_oe_n) ? 0 : lo_cnt + 1;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    cnt_dec_a: assert property (run && cmd.instr_tick && runaway_down_counter != '0
        |=> runaway_down_counter == $past(runaway_down_counter) - 1'b1) else $error("no step");
    flag_set_a: assert property (uf && !status.first_underflow_flag
        |=> status.first_underflow_flag) else $error("flag not set");
    wd_fire_a: assert property (uf && status.first_underflow_flag && status.guard_enable_flag
        |=> status.second_underflow_flag && !reset_pin_oe_n) else $error("no fire");
    no_fire_a: assert property (!status.guard_enable_flag && !status.watchdog_reset
        |=> !status.watchdog_reset) else $error("fired while off");
    skip_set_a: assert property (run && !cmd.instr_tick && cmd.retire
        && cmd.op == PRW_OP_GUARD_RESTART && status.first_underflow_flag
        |=> status.skip_next && !status.first_underflow_flag) else $error("no skip");
    no_skip_a: assert property (!status.first_underflow_flag
        |=> !status.skip_next) else $error("bad skip");
    pd_init_a: assert property (cmd.power_down_entry && !status.watchdog_reset && reset_pin_in
        |=> &runaway_down_counter && !status.first_underflow_flag && status.guard_enable_flag)
        else $error("no reinit");
    pulse_end_a: assert property ($rose(reset_pin_oe_n) |-> lo_cnt == HOLD_CYC
        && &runaway_down_counter && !status.first_underflow_flag
        && !status.second_underflow_flag && status.guard_enable_flag) else $error("bad pulse");
    ext_init_a: assert property (!reset_pin_in && reset_pin_oe_n
        |=> &runaway_down_counter && !status.first_underflow_flag && status.guard_enable_flag)
        else $error("no foreign reset");
    fire_c: cover property (uf && status.first_underflow_flag && status.guard_enable_flag);
    ext_c: cover property (!reset_pin_in && reset_pin_oe_n);
    skip_c: cover property (status.skip_next);
    pd_c: cover property (cmd.power_down_entry);
endmodule
bind prw_watchdog prw_watchdog_mon #(.CNT_W(CNT_W), .HOLD_CYC(HOLD_CYC)) u_mon (
    .ref_clk(ref_clk), .srst(srst), .cmd(cmd), .status(status),
    .runaway_down_counter(runaway_down_counter), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n));
`default_nettype wire

// >>> dv/prw_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module prw_cpu_model
(
    // clock
    input wire logic ref_clk,
    // instruction stream
    input wire prw_pkg::prw_cmd_t req,
    output var prw_pkg::prw_cmd_t cmd,
    // watchdog side
    input wire prw_pkg::prw_status_t status,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    input wire logic pull_req,
    output logic reset_pin_in
);
    import prw_pkg::*;
    logic pend = 1'b0;
    logic pull = 1'b0;
    prw_cmd_t c;
    // pull-up: a released pin reads high; a foreign reset pulls it low
    assign reset_pin_in = !pull && (reset_pin_oe_n || reset_pin_out);
    always @(negedge ref_clk)
    begin
        c = req;
        pend = (pend || status.skip_next) && !status.watchdog_reset;
        // a skipped instruction retires as nothing
        if (pend && c.retire)
        begin
            c = '0;
            pend = 1'b0;
        end
        cmd <= c;
        pull <= pull_req;
    end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import prw_pkg::*;
    localparam int W = 4;
    localparam int H = 4;
    localparam int MX = 2 ** W - 1;
    // step codes: 0..4 retire op, 5 tick, 6 idle, 7 entry, 8 return, 9 pin pulled; then count
    localparam int PL[52] = '{5, 32, 6, 6,
        5, 16, 1, 1, 0, 1, 1, 1,
        2, 1, 0, 1, 1, 1, 5, 40, 6, 6,
        2, 1, 6, 1, 1, 1, 5, 40, 1, 1, 0, 1,
        9, 1,
        7, 1, 2, 1, 1, 1, 8, 1, 1, 1, 3, 1, 4, 1, 7, 1};
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    prw_cmd_t req = '0;
    prw_cmd_t cmd;
    prw_status_t status;
    logic [W-1:0] cnt_o;
    logic pin_in;
    logic pull = 1'b0;
    logic pin_out;
    logic pin_oe_n;
    logic [W+6:0] exp_v;
    logic f1 = 1'b0, f2 = 1'b0, wdr = 1'b0, sk = 1'b0, arm = 1'b0, en = 1'b1;
    logic [31:0] r;
    int fail_count = 0;
    int samples_checked = 0;
    int seed = 32'h3cec;
    int m_cnt = MX;
    int m_hold = 0;
    always #10 ref_clk = ~ref_clk;
    prw_watchdog #(.CNT_W(W), .HOLD_CYC(H)) DUT (.ref_clk(ref_clk), .srst(srst), .cmd(cmd),
        .status(status), .runaway_down_counter(cnt_o), .reset_pin_in(pin_in),
        .reset_pin_out(pin_out), .reset_pin_oe_n(pin_oe_n));
    prw_cpu_model cpu (.ref_clk(ref_clk), .req(req), .cmd(cmd), .status(status),
        .reset_pin_out(pin_out), .reset_pin_oe_n(pin_oe_n), .pull_req(pull),
        .reset_pin_in(pin_in));
    always @(posedge ref_clk)
    begin
        // a foreign low on the pin acts as a system reset while we are not driving it
        if (srst || (wdr && m_hold == H - 1) || (!wdr && !pin_in))
        begin
            {f1, f2, wdr, sk, arm, en} = 6'h01;
            m_cnt = MX;
            m_hold = 0;
        end
        else if (wdr)
            m_hold++;
        else
        begin
            sk = 1'b0;
            if (cmd.power_down_entry)
            begin
                m_cnt = MX;
                f1 = 1'b0;
                en = 1'b1;
            end
            else if (cmd.instr_tick && m_cnt == 0)
            begin
                m_cnt = MX;
                wdr = f1 && en;
                f2 = wdr;
                f1 = 1'b1;
            end
            else if (cmd.instr_tick)
                m_cnt--;
            if (cmd.retire && cmd.op == PRW_OP_GUARD_RESTART)
            begin
                sk = f1;
                f1 = 1'b0;
                en = en && !arm;
            end
            if (cmd.retire)
                arm = cmd.op == PRW_OP_GUARD_DISABLE;
            en = en || cmd.power_down_return;
        end
    end
    assign exp_v = {en, f1, f2, wdr, sk, W'(m_cnt), !wdr, 1'b0};
    always @(negedge ref_clk)
    begin
        samples_checked++;
        if ({status, cnt_o, pin_oe_n, pin_out} !== exp_v)
        begin
            fail_count++;
            $display("mismatch at %0t: got %b want %b", $time,
                {status, cnt_o, pin_oe_n, pin_out}, exp_v);
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic st(input int k, input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            req <= '{k == 5, k < 5, prw_op_t'(3'(k % 5)), k == 7, k == 8};
            pull <= k == 9;
        end
    endtask
    task automatic rand_run(input int n);
        repeat (n)
        begin
            r = $random(seed);
            st(r[1:0] == 2'h0 ? 5 : r[1] ? 6 : int'(r[4:2] % 3'h5), 1);
        end
    endtask
    initial
    begin
        #200000;
        fail_count++;
        end_sim();
    end
    initial
    begin
        repeat (12) @(negedge ref_clk);
        srst <= 1'b0;
        for (int i = 0; i < 52; i += 2)
            st(PL[i], PL[i + 1]);
        rand_run(1500);
        @(negedge ref_clk);
        srst <= 1'b1;
        req <= '0;
        repeat (3) @(negedge ref_clk);
        srst <= 1'b0;
        rand_run(500);
        end_sim();
    end
endmodule
`default_nettype wire
